// file: pwc_config.sv
//Contract
// - Start level one: output high at period start, low at duty match.
// - Start level zero: output low at period start, high at duty match.
// - Start level bits writable anytime, applied at once.
// - Channels 0,1,4,5: AB/scaled 00 A, 01 SA, 10 B, 11 SB.
// - Channels 2,3,6,7: AB/scaled 00 B, 01 SB, 10 A, 11 SA.
// - Clock A/B is bus clock over two to the 3-bit code.
// - Clock selects and prescale codes writable anytime, applied at once.
// - Per-channel bit picks center or left alignment.
// - Join bit forms 16-bit channel; even channel is high byte.
// - Join bits: 7 pair 6/7, 6 pair 4/5, 5 pair 2/3, 4 pair 0/1.
// - Joined pair: odd pin and odd channel's controls govern.
// - Bits of absent channels or pairs ignore writes, read zero.
// - Wait-stop bit gates prescaler input in wait mode.
// - Freeze-stop bit gates prescaler input in freeze mode.
// - Scaled clock is clock over twice scale; zero means 256.
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pwc_config #(
	parameter int unsigned CH_COUNT = 8
) (
	input  wire logic        CLK_I,
	input  wire logic        RESET_N_I,
	input  wire logic        WAIT_MODE_I,
	input  wire logic        FREEZE_MODE_I,
	input  wire logic [7:0]  AWADDR_I,
	input  wire logic        AWVALID_I,
	output logic             AWREADY_O,
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output logic             WREADY_O,
	output logic [1:0]       BRESP_O,
	output logic             BVALID_O,
	input  wire logic        BREADY_I,
	input  wire logic [7:0]  ARADDR_I,
	input  wire logic        ARVALID_I,
	output logic             ARREADY_O,
	output logic [31:0]      RDATA_O,
	output logic [1:0]       RRESP_O,
	output logic             RVALID_O,
	input  wire logic        RREADY_I,
	output logic [7:0]       PWM_O
);

	localparam int unsigned NCH = pwc_pkg::MAX_CH;
	localparam logic [8:0] LIVE_WIDE = (9'h001 << CH_COUNT) - 9'h001;
	localparam logic [7:0] LIVE = LIVE_WIDE[7:0];
	localparam logic [3:0] PAIR_LIVE = {LIVE[7], LIVE[5], LIVE[3], LIVE[1]};

	typedef struct packed {
		logic [7:0]          enable;
		logic [7:0]          start_level_bits;
		logic [7:0]          scaled_select;
		logic [7:0]          a_or_b_clock_choice;
		logic [2:0]          clock_a_divider_code;
		logic [2:0]          clock_b_divider_code;
		logic [7:0]          center_mode_bits;
		logic [3:0]          join_bits;
		logic                wait_stop_bit;
		logic                freeze_stop_bit;
		logic [7:0]          scale_value_a;
		logic [7:0]          scale_value_b;
		logic [NCH-1:0][7:0] period;
		logic [NCH-1:0][7:0] duty;
		logic [6:0]          prescale;
		logic                aw_have;
		logic [7:0]          aw_addr;
		logic                w_have;
		logic [7:0]          w_data;
		logic                w_lane0;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		logic [7:0]          pwm;
	} pwc_top_st_t;

	pwc_top_st_t st_q;
	pwc_top_st_t st_d;

	logic                   run;
	logic [6:0]             mask_a;
	logic [6:0]             mask_b;
	logic                   tick_a;
	logic                   tick_b;
	logic                   tick_sa;
	logic                   tick_sb;
	logic                   load_a;
	logic                   load_b;
	logic [7:0]             restart;
	logic [7:0]             joined;
	logic [7:0]             wave;
	logic [7:0]             ch_tick;
	logic [NCH-1:0][15:0]   count;
	pwc_pkg::pwc_chan_cfg_t cfg [NCH];

	////////////////////////////////////////////////////////////////////////
	// prescaler

	// gate prescaler in wait or freeze
	assign run = |(st_q.enable & LIVE)
		& ~(WAIT_MODE_I & st_q.wait_stop_bit)
		& ~(FREEZE_MODE_I & st_q.freeze_stop_bit);

	// divide by two to the code
	assign mask_a = ~(pwc_pkg::PRESCALE_FULL << st_q.clock_a_divider_code);
	assign mask_b = ~(pwc_pkg::PRESCALE_FULL << st_q.clock_b_divider_code);
	assign tick_a = run & ((st_q.prescale | ~mask_a) == pwc_pkg::PRESCALE_FULL);
	assign tick_b = run & ((st_q.prescale | ~mask_b) == pwc_pkg::PRESCALE_FULL);

	pwc_scaler u_scale_a (
		.clk_i   (CLK_I),
		.rst_n_i (RESET_N_I),
		.tick_i  (tick_a),
		.load_i  (load_a),
		.scale_i (st_q.scale_value_a),
		.stick_o (tick_sa)
	);

	pwc_scaler u_scale_b (
		.clk_i   (CLK_I),
		.rst_n_i (RESET_N_I),
		.tick_i  (tick_b),
		.load_i  (load_b),
		.scale_i (st_q.scale_value_b),
		.stick_o (tick_sb)
	);

	////////////////////////////////////////////////////////////////////////
	// channels

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			localparam int unsigned MATE = gi ^ 1;
			logic use_b;

			assign joined[gi] = st_q.join_bits[gi / 2] & PAIR_LIVE[gi / 2];

			// second group swaps A and B
			assign use_b       = st_q.a_or_b_clock_choice[gi] ^ ((gi & 2) != 0);
			assign ch_tick[gi] = use_b
				? (st_q.scaled_select[gi] ? tick_sb : tick_b)
				: (st_q.scaled_select[gi] ? tick_sa : tick_a);

			// even half of joined pair stays off
			assign cfg[gi].enable     = st_q.enable[gi] & LIVE[gi] & ~(joined[gi] & ((gi & 1) == 0));
			assign cfg[gi].start_high = st_q.start_level_bits[gi];
			assign cfg[gi].center     = st_q.center_mode_bits[gi];
			assign cfg[gi].restart    = restart[gi] | restart[MATE] & joined[gi];

			// even channel holds the high byte
			assign cfg[gi].period = (joined[gi] && (gi & 1) == 1)
				? {st_q.period[MATE], st_q.period[gi]} : {8'h00, st_q.period[gi]};
			assign cfg[gi].duty   = (joined[gi] && (gi & 1) == 1)
				? {st_q.duty[MATE], st_q.duty[gi]} : {8'h00, st_q.duty[gi]};

			pwc_channel u_ch (
				.clk_i   (CLK_I),
				.rst_n_i (RESET_N_I),
				.tick_i  (ch_tick[gi]),
				.cfg_i   (cfg[gi]),
				.wave_o  (wave[gi]),
				.count_o (count[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// register read

	function automatic logic [33:0] read_word(input logic [7:0] a);
		logic [7:0] v;
		logic [2:0] idx;
		logic       ok;
		v   = 8'h00;
		idx = a[4:2];
		ok  = (a[1:0] == 2'b00);
		case (a[7:5])
			pwc_pkg::PAGE_PERIOD:  v = st_q.period[idx];
			pwc_pkg::PAGE_DUTY:    v = st_q.duty[idx];
			pwc_pkg::PAGE_COUNTER: v = (joined[idx] && !idx[0])
				? count[idx ^ 3'h1][15:8] : count[idx][7:0];
			default: begin
				case (a)
					pwc_pkg::OFF_ENABLE:   v = st_q.enable;
					pwc_pkg::OFF_POLARITY: v = st_q.start_level_bits;
					pwc_pkg::OFF_CLK_SEL:  v = st_q.scaled_select;
					pwc_pkg::OFF_PRESCALE: v = {1'b0, st_q.clock_b_divider_code,
						1'b0, st_q.clock_a_divider_code};
					pwc_pkg::OFF_CENTER:   v = st_q.center_mode_bits;
					pwc_pkg::OFF_CONTROL:  v = {st_q.join_bits, st_q.wait_stop_bit,
						st_q.freeze_stop_bit, 2'b00};
					pwc_pkg::OFF_AB_SEL:   v = st_q.a_or_b_clock_choice;
					pwc_pkg::OFF_SCALE_A:  v = st_q.scale_value_a;
					pwc_pkg::OFF_SCALE_B:  v = st_q.scale_value_b;
					default:               ok = 1'b0;
				endcase
			end
		endcase
		if (a[7:5] == pwc_pkg::PAGE_PERIOD || a[7:5] == pwc_pkg::PAGE_DUTY
			|| a[7:5] == pwc_pkg::PAGE_COUNTER) begin
			if (!LIVE[idx]) begin
				v = 8'h00;
			end
		end
		return {ok ? pwc_pkg::RESP_OKAY : pwc_pkg::RESP_SLVERR, 24'h000000, v};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus and register write

	always_comb begin
		logic [7:0] a;
		logic [7:0] wd;
		logic       ok;
		logic [2:0] idx;
		logic [33:0] rd;
		a       = 8'h00;
		wd      = 8'h00;
		ok      = 1'b0;
		idx     = 3'h0;
		rd      = '0;
		st_d    = st_q;
		load_a  = 1'b0;
		load_b  = 1'b0;
		restart = 8'h00;

		st_d.prescale = run ? st_q.prescale + 7'h01 : st_q.prescale;
		st_d.pwm      = wave;

		if (st_q.bvalid && BREADY_I) begin
			st_d.bvalid = 1'b0;
		end
		if (st_q.awready && AWVALID_I) begin
			st_d.aw_have = 1'b1;
			st_d.aw_addr = AWADDR_I;
		end
		if (st_q.wready && WVALID_I) begin
			st_d.w_have  = 1'b1;
			st_d.w_data  = WDATA_I[7:0];
			st_d.w_lane0 = WSTRB_I[0];
		end

		if (st_d.aw_have && st_d.w_have && !st_q.bvalid) begin
			a   = st_d.aw_addr;
			wd  = st_d.w_data;
			idx = a[4:2];
			ok  = (a[1:0] == 2'b00);
			st_d.aw_have = 1'b0;
			st_d.w_have  = 1'b0;
			st_d.bvalid  = 1'b1;
			case (a[7:5])
				pwc_pkg::PAGE_PERIOD: begin
					if (ok && st_d.w_lane0 && LIVE[idx]) st_d.period[idx] = wd;
				end
				pwc_pkg::PAGE_DUTY: begin
					if (ok && st_d.w_lane0 && LIVE[idx]) st_d.duty[idx] = wd;
				end
				pwc_pkg::PAGE_COUNTER: begin
					if (ok && st_d.w_lane0 && LIVE[idx]) restart[idx] = 1'b1;
				end
				default: begin
					ok = ok & st_d.w_lane0 | ok & ~st_d.w_lane0;
					case (a)
						pwc_pkg::OFF_ENABLE:
							if (st_d.w_lane0) st_d.enable = wd & LIVE;
						pwc_pkg::OFF_POLARITY:
							if (st_d.w_lane0) st_d.start_level_bits = wd & LIVE;
						pwc_pkg::OFF_CLK_SEL:
							if (st_d.w_lane0) st_d.scaled_select = wd & LIVE;
						pwc_pkg::OFF_PRESCALE:
							if (st_d.w_lane0) begin
								st_d.clock_a_divider_code = wd[pwc_pkg::PRE_A_LSB +: 3];
								st_d.clock_b_divider_code = wd[pwc_pkg::PRE_B_LSB +: 3];
							end
						pwc_pkg::OFF_CENTER:
							if (st_d.w_lane0) st_d.center_mode_bits = wd & LIVE;
						pwc_pkg::OFF_CONTROL:
							if (st_d.w_lane0) begin
								st_d.join_bits       = wd[pwc_pkg::CTL_JOIN_LSB +: 4] & PAIR_LIVE;
								st_d.wait_stop_bit   = wd[pwc_pkg::CTL_WAIT_BIT];
								st_d.freeze_stop_bit = wd[pwc_pkg::CTL_FRZ_BIT];
							end
						pwc_pkg::OFF_AB_SEL:
							if (st_d.w_lane0) st_d.a_or_b_clock_choice = wd & LIVE;
						pwc_pkg::OFF_SCALE_A:
							if (st_d.w_lane0) begin
								st_d.scale_value_a = wd;
								load_a             = 1'b1;
							end
						pwc_pkg::OFF_SCALE_B:
							if (st_d.w_lane0) begin
								st_d.scale_value_b = wd;
								load_b             = 1'b1;
							end
						default: ok = 1'b0;
					endcase
				end
			endcase
			st_d.bresp = ok ? pwc_pkg::RESP_OKAY : pwc_pkg::RESP_SLVERR;
		end
		st_d.awready = ~st_d.aw_have & ~st_d.bvalid;
		st_d.wready  = ~st_d.w_have & ~st_d.bvalid;

		if (st_q.rvalid && RREADY_I) begin
			st_d.rvalid = 1'b0;
		end
		if (st_q.arready && ARVALID_I) begin
			rd          = read_word(ARADDR_I);
			st_d.rvalid = 1'b1;
			st_d.rdata  = rd[31:0];
			st_d.rresp  = rd[33:32];
		end
		st_d.arready = ~st_d.rvalid;
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign AWREADY_O = st_q.awready;
	assign WREADY_O  = st_q.wready;
	assign BVALID_O  = st_q.bvalid;
	assign BRESP_O   = st_q.bresp;
	assign ARREADY_O = st_q.arready;
	assign RVALID_O  = st_q.rvalid;
	assign RDATA_O   = st_q.rdata;
	assign RRESP_O   = st_q.rresp;
	assign PWM_O     = st_q.pwm;

endmodule

`default_nettype wire

// file: pwc_pkg.sv
package pwc_pkg;

	localparam int unsigned MAX_CH = 8;

	// register byte offsets and address pages (bits 7:5)
	localparam logic [7:0] OFF_ENABLE    = 8'h00;
	localparam logic [7:0] OFF_POLARITY  = 8'h04;
	localparam logic [7:0] OFF_CLK_SEL   = 8'h08;
	localparam logic [7:0] OFF_PRESCALE  = 8'h0C;
	localparam logic [7:0] OFF_CENTER    = 8'h10;
	localparam logic [7:0] OFF_CONTROL   = 8'h14;
	localparam logic [7:0] OFF_AB_SEL    = 8'h18;
	localparam logic [7:0] OFF_SCALE_A   = 8'h1C;
	localparam logic [7:0] OFF_SCALE_B   = 8'h20;
	localparam logic [2:0] PAGE_PERIOD   = 3'h2;
	localparam logic [2:0] PAGE_DUTY     = 3'h3;
	localparam logic [2:0] PAGE_COUNTER  = 3'h4;

	// field positions
	localparam int unsigned CTL_JOIN_LSB = 4;
	localparam int unsigned CTL_WAIT_BIT = 3;
	localparam int unsigned CTL_FRZ_BIT  = 2;
	localparam int unsigned PRE_A_LSB    = 0;
	localparam int unsigned PRE_B_LSB    = 4;

	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [6:0] PRESCALE_RESET = 7'h00;
	localparam logic [6:0] PRESCALE_FULL  = 7'h7F;
	localparam logic [7:0] SCALE_RELOAD   = 8'h01;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic        enable;
		logic        start_high;
		logic        center;
		logic        restart;
		logic [15:0] period;
		logic [15:0] duty;
	} pwc_chan_cfg_t;

endpackage

// file: pwc_scaler.sv
`timescale 1ns/1ps
`default_nettype none

module pwc_scaler (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       tick_i,
	input  wire logic       load_i,
	input  wire logic [7:0] scale_i,
	output logic            stick_o
);

	typedef struct packed {
		logic [7:0] cnt;
		logic       half;
	} pwc_scl_st_t;

	pwc_scl_st_t st_q;
	pwc_scl_st_t st_d;

	always_comb begin
		st_d    = st_q;
		stick_o = 1'b0;
		if (load_i) begin
			st_d.cnt  = scale_i;
			st_d.half = 1'b0;
		end else if (tick_i) begin
			if (st_q.cnt == pwc_pkg::SCALE_RELOAD) begin
				st_d.cnt  = scale_i;
				st_d.half = ~st_q.half;
				stick_o   = st_q.half;
			end else begin
				// zero wraps to 255, so a zero scale counts 256
				st_d.cnt = st_q.cnt - 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule

`default_nettype wire

// file: pwc_channel.sv
`timescale 1ns/1ps
`default_nettype none

module pwc_channel (
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   tick_i,
	input  wire pwc_pkg::pwc_chan_cfg_t cfg_i,
	output logic                        wave_o,
	output logic [15:0]                 count_o
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        down;
		logic [15:0] per;
		logic [15:0] dty;
	} pwc_ch_st_t;

	pwc_ch_st_t st_q;
	pwc_ch_st_t st_d;

	always_comb begin
		st_d = st_q;
		if (cfg_i.restart) begin
			st_d.cnt  = 16'h0000;
			st_d.down = 1'b0;
			st_d.per  = cfg_i.period;
			st_d.dty  = cfg_i.duty;
		end else if (!cfg_i.enable) begin
			st_d.per = cfg_i.period;
			st_d.dty = cfg_i.duty;
		end else if (tick_i) begin
			if (cfg_i.center) begin
				if (st_q.down) begin
					if (st_q.cnt <= 16'h0001) begin
						st_d.cnt  = 16'h0000;
						st_d.down = 1'b0;
						st_d.per  = cfg_i.period;
						st_d.dty  = cfg_i.duty;
					end else begin
						st_d.cnt = st_q.cnt - 16'h0001;
					end
				end else if (st_q.cnt >= st_q.per) begin
					st_d.down = (st_q.per != 16'h0000);
					st_d.cnt  = (st_q.per == 16'h0000) ? 16'h0000 : st_q.cnt - 16'h0001;
				end else begin
					st_d.cnt = st_q.cnt + 16'h0001;
				end
			end else begin
				if (st_q.cnt + 16'h0001 >= st_q.per) begin
					st_d.cnt  = 16'h0000;
					st_d.down = 1'b0;
					st_d.per  = cfg_i.period;
					st_d.dty  = cfg_i.duty;
				end else begin
					st_d.cnt = st_q.cnt + 16'h0001;
				end
			end
		end
	end

	// live start level, flip at duty
	assign wave_o  = cfg_i.enable & ~(cfg_i.start_high ^ (st_q.cnt < st_q.dty));
	assign count_o = st_q.cnt;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule

`default_nettype wire

// file: pwc_config_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pwc_config_chk #(
	parameter int unsigned CH_COUNT = 8
) (
	input wire logic        CLK_I,
	input wire logic        RESET_N_I,
	input wire logic        AWVALID_I,
	input wire logic        AWREADY_O,
	input wire logic        WVALID_I,
	input wire logic        WREADY_O,
	input wire logic [1:0]  BRESP_O,
	input wire logic        BVALID_O,
	input wire logic        BREADY_I,
	input wire logic [7:0]  ARADDR_I,
	input wire logic        ARVALID_I,
	input wire logic        ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic [1:0]  RRESP_O,
	input wire logic        RVALID_O,
	input wire logic        RREADY_I,
	input wire logic [7:0]  PWM_O
);
	default clocking dcb @(posedge CLK_I);
	endclocking
	default disable iff (!RESET_N_I);
	////////////////////////////////////////
	sequence s_wr_take;
		AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
	endsequence
	sequence s_rd_take;
		ARVALID_I && ARREADY_O;
	endsequence
	////////////////////////////////////////
	a_wr_answer: assert property (s_wr_take |=> BVALID_O && !AWREADY_O && !WREADY_O)
		else $error("no write response after take");
	a_bresp_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
		else $error("write response dropped early");
	a_b_release: assert property (BVALID_O && BREADY_I |=> !BVALID_O && AWREADY_O && WREADY_O)
		else $error("write channel not freed");
	a_rd_answer: assert property (s_rd_take |=> RVALID_O && !ARREADY_O && RDATA_O[31:8] == 24'h000000)
		else $error("bad read answer");
	a_rdata_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
		else $error("read data dropped early");
	a_r_release: assert property (RVALID_O && RREADY_I |=> !RVALID_O && ARREADY_O)
		else $error("read channel not freed");
	a_unmapped_err: assert property (s_rd_take and ARADDR_I inside {[8'h24:8'h3C]}
		|=> RRESP_O == pwc_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
	a_reset_idle: assert property ($rose(RESET_N_I) |-> (PWM_O == 8'h00)[*3])
		else $error("output active after reset");
	a_absent_quiet: assert property ((PWM_O >> CH_COUNT) == 8'h00)
		else $error("absent channel drives output");
endmodule
bind pwc_config pwc_config_chk #(.CH_COUNT(CH_COUNT)) u_chk (
	.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
	.WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O),
	.BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
	.RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
	.PWM_O(PWM_O)
);
`default_nettype wire

// file: pwc_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pwc_config_tb_top;
	logic        clk, rst_n, wait_m, frz_m;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr, pwm;
	logic [31:0] wdata, rdata, rd_v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rp, wp;
	int          failures, checks_done, hi, rs, cyc;

	pwc_config #(.CH_COUNT(6)) u_dut (
		.CLK_I(clk), .RESET_N_I(rst_n), .WAIT_MODE_I(wait_m), .FREEZE_MODE_I(frz_m),
		.AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
		.WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
		.BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
		.ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
		.RREADY_I(rready), .PWM_O(pwm)
	);
	////////////////////////////////////////
	// late > 0 holds the response pending for that many cycles
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input int late = 0);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= (late == 0);
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		if (late > 0) begin
			repeat (late) @(posedge clk);
			bready <= 1'b1;
			@(posedge clk);
		end
		bready <= 1'b0;
		wp = bresp;
	endtask
	task automatic rd(input logic [7:0] a, input int late = 0);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= (late == 0);
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		if (late > 0) begin
			repeat (late) @(posedge clk);
			rready <= 1'b1;
			@(posedge clk);
		end
		rready <= 1'b0;
		rd_v = rdata;
		rp = rresp;
	endtask
	task automatic chk(input string s, input int e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %0h seen %0h", s, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input int e, input string s);
		rd(a);
		chk(s, e, rd_v);
	endtask
	// high cycles and rising edges over n cycles
	task automatic meas(input int ch, input int n);
		logic p;
		repeat (4) @(posedge clk);
		hi = 0;
		rs = 0;
		p = pwm[ch];
		repeat (n) begin
			@(posedge clk);
			if (pwm[ch] === 1'b1) hi++;
			if (pwm[ch] === 1'b1 && p === 1'b0) rs++;
			p = pwm[ch];
		end
	endtask
	task automatic rise(input int ch);
		logic p;
		p = pwm[ch];
		@(posedge clk);
		while (!(pwm[ch] === 1'b1 && p === 1'b0)) begin
			p = pwm[ch];
			@(posedge clk);
		end
	endtask
	task automatic per(input int ch);
		time t;
		rise(ch);
		rise(ch);
		t = $time;
		rise(ch);
		cyc = int'(($time - t) / 100);
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#6000000;
		failures++;
		end_sim();
	end
	initial begin
		{rst_n, wait_m, frz_m, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 9; i++) rdc(8'(4 * i), 0, "reset value");
		rd(8'h24);
		chk("unmapped resp", int'(pwc_pkg::RESP_SLVERR), {30'h0, rp});
		wr(8'h24, 8'hFF);
		chk("unmapped bresp", int'(pwc_pkg::RESP_SLVERR), {30'h0, wp});
		wr(8'h41, 8'hAA);
		chk("misaligned bresp", int'(pwc_pkg::RESP_SLVERR), {30'h0, wp});
		rdc(8'h40, 0, "misaligned write");
		wstrb <= 4'hE;
		wr(8'h1C, 8'h55);
		wstrb <= 4'hF;
		chk("strobe bresp", int'(pwc_pkg::RESP_OKAY), {30'h0, wp});
		rdc(8'h1C, 0, "strobe off");
		for (int i = 0; i < 7; i++) begin
			wr(8'(4 * i), 8'hFF);
			rdc(8'(4 * i), (i == 3) ? 'h77 : (i == 5) ? 'h7C : 'h3F, "readback");
			wr(8'(4 * i), 8'h00);
		end
		wr(8'h40, 8'h04);
		wr(8'h60, 8'h01);
		wr(8'h48, 8'h04, 2);
		wr(8'h68, 8'h01);
		rd(8'h48, 3);
		chk("late read", 4, rd_v);
		wr(8'h00, 8'h05);
		wr(8'h04, 8'h01);
		meas(0, 40); chk("ch0 high", 10, hi);
		meas(2, 40); chk("ch2 high", 30, hi);
		wr(8'h04, 8'h04);
		meas(0, 40); chk("ch0 high", 30, hi);
		meas(2, 40); chk("ch2 high", 10, hi);
		wr(8'h04, 8'h00);
		for (int k = 0; k < 7; k++) begin
			wr(8'h0C, 8'((k + 1) * 16 + k));
			for (int s = 0; s < 2; s++) begin
				wr(8'h18, s ? 8'h05 : 8'h00);
				per(0); chk("ch0 period", 4 << (s ? k + 1 : k), cyc);
				per(2); chk("ch2 period", 4 << (s ? k : k + 1), cyc);
			end
		end
		wr(8'h0C, 8'h10);
		wr(8'h1C, 8'h02);
		wr(8'h20, 8'h03);
		wr(8'h08, 8'h05);
		for (int s = 0; s < 2; s++) begin
			wr(8'h18, s ? 8'h05 : 8'h00);
			per(0); chk("ch0 scaled", s ? 48 : 16, cyc);
			per(2); chk("ch2 scaled", s ? 16 : 48, cyc);
		end
		wr(8'h1C, 8'h00);
		per(2); chk("scale zero", 2048, cyc);
		wr(8'h18, 8'h00);
		wr(8'h08, 8'h00);
		wr(8'h0C, 8'h00);
		wr(8'h00, 8'h04);
		wr(8'h10, 8'h01);
		wr(8'h00, 8'h05);
		per(0); chk("center period", 8, cyc);
		per(2); chk("left period", 4, cyc);
		wr(8'h00, 8'h00);
		wr(8'h10, 8'h00);
		wr(8'h14, 8'h10);
		wr(8'h40, 8'h01);
		wr(8'h44, 8'h00);
		wr(8'h60, 8'h00);
		wr(8'h64, 8'h80);
		wr(8'h04, 8'h02);
		wr(8'h00, 8'h02);
		per(1); chk("joined period", 256, cyc);
		meas(1, 512); chk("joined high", 256, hi);
		meas(0, 256); chk("even pin", 0, hi);
		wr(8'h14, 8'h18);
		wait_m <= 1'b1;
		meas(1, 512); chk("wait gated", 0, rs);
		wr(8'h14, 8'h10);
		meas(1, 512); chk("wait running", 2, rs);
		wr(8'h14, 8'h14);
		wait_m <= 1'b0;
		frz_m <= 1'b1;
		meas(1, 512); chk("freeze gated", 0, rs);
		rdc(8'h14, 'h14, "freeze access");
		wr(8'h84, 8'h00);
		rdc(8'h84, 0, "counter restart");
		rdc(8'h80, 0, "joined high count");
		frz_m <= 1'b0;
		meas(1, 512); chk("freeze ended", 2, rs);
		end_sim();
	end
endmodule
`default_nettype wire
